// file: core/simd_ext_pkg.sv
// Purpose: Shared constants and types for the SIMD extension state and access control.
// Assumes: One core clock, synchronous active-low reset, one request per accepted cycle.
// Notes:   Field positions, reset values and counts live here; other files also write some of them as literals.
// Operation
// - Four accumulator pairs; a 2-bit selector, value zero is the base accumulator.
// - Compares write 1, 2, 4 or 8 condition bits at 31:24; selects read them.
// - Overflow bits 23:16 are sticky; only a full-register write clears them.
// - Saturating MAC and dot products set bit 16 to 19 by target accumulator.
// - Abs, add, subtract and add-with-carry set bit 20 on overflow.
// - Multiplies returning to general registers set bit 21 on overflow.
// - Precision reduction and left shifts set bit 22 on overflow.
// - Accumulator extracts set bit 23 on overflow.
// - Positional extracts write bit 14: one if position below size, else zero.
// - Carry-generating add writes bit 13; add-with-carry uses it as carry in.
// - Variable inserts take field width from bits 12:7.
// - Bits 6:0 hold position; decrementing extracts subtract size plus one on success.
// - Move low to high copies low to high, then adds 32, or 64 doubled.
// - Bit 15 is reserved, reads zero, and software writes zero there.
// - Branches, positional extracts and inserts read position; inserts also read size.
// - Config bits 10 and 11 show base and revision-2 presence, fixed, read-only.
// - Missing base or revision-2 support raises a reserved-instruction exception; a rev2 opcode on a present but disabled extension gets the disabled one.
// - Present but disabled extension raises the disabled exception, code 26.
// - One status enable bit enables or disables every extension sharing it.
// - Enabled extension: invalid opcodes raise reserved-instruction, valid ones nothing.
// - Hardware interlocks control register and accumulator dependencies.

`default_nettype none

package simd_ext_pkg;

  // ===========================================================================
  // Control register layout.
  localparam int unsigned CCOND_LSB     = 24;
  localparam int unsigned OUFLAG_LSB    = 16;
  localparam int unsigned OU_ADDSUB_BIT = 20;
  localparam int unsigned OU_MUL_BIT    = 21;
  localparam int unsigned OU_PREC_BIT   = 22;
  localparam int unsigned OU_ACCUMULATOR_EXTRACT_BIT   = 23;
  localparam int unsigned RSVD_BIT      = 15;
  localparam int unsigned EFI_BIT       = 14;
  localparam int unsigned CARRY_BIT     = 13;
  localparam int unsigned SCOUNT_LSB    = 7;
  localparam int unsigned SCOUNT_W      = 6;
  localparam int unsigned POS_LSB       = 0;
  localparam int unsigned POS_W         = 7;
  localparam logic [31:0] CTRL_RESET    = 32'h0000_0000;
  localparam logic [31:0] CTRL_WR_MASK  = 32'hffff_7fff;

  // ===========================================================================
  // Configuration, status and cause values.
  localparam int unsigned CFG_BASE_BIT  = 10;
  localparam int unsigned CFG_REV2_BIT  = 11;
  localparam int unsigned STAT_EN_BIT   = 24;
  localparam logic        EN_RESET      = 1'b0;
  localparam logic [4:0]  EXC_DISABLED  = 5'h1a;
  localparam logic [4:0]  EXC_RESERVED  = 5'h0a;

  // ===========================================================================
  // Accumulators and position arithmetic.
  localparam int unsigned NUM_ACC       = 4;
  localparam logic [6:0]  POS_ADV_WORD  = 7'h20;
  localparam logic [6:0]  POS_ADV_DBL   = 7'h40;
  localparam logic [6:0]  POS_GE_WORD   = 7'h20;
  localparam logic [6:0]  POS_GE_DBL    = 7'h40;

  typedef enum logic [4:0] {
    OP_OTHER,
    OP_WRITE_FULL,
    OP_READ_FULL,
    OP_COMPARE,
    OP_SELECT,
    OP_MAC_SAT,
    OP_ADDSUB,
    OP_ADD_GEN_CARRY,
    OP_ADD_USE_CARRY,
    OP_MUL_GPR,
    OP_PREC_SHIFT,
    OP_ACC_EXTRACT,
    OP_POS_EXTRACT,
    OP_POS_EXTRACT_DEC,
    OP_VAR_INSERT,
    OP_MOVE_LH,
    OP_MOVE_LH_DOUBLE,
    OP_BRANCH_POS32,
    OP_BRANCH_POS64,
    OP_ACC_WRITE,
    OP_ACC_READ
  } op_t;

endpackage : simd_ext_pkg

`default_nettype wire

// file: core/ext_exception_select.sv
// Purpose: Picks the extension-related exception for one instruction.
// Assumes: Presence inputs are constant; the enable is the shared status bit.
// Notes:   Purely combinational; the caller registers the result.

`default_nettype none

module ext_exception_select
  import simd_ext_pkg::*;
(
  input  wire logic       base_present,
  input  wire logic       rev2_present,
  input  wire logic       ext_enable,
  input  wire logic       touches_ext,
  input  wire logic       is_rev2,
  input  wire logic       valid_base,
  input  wire logic       valid_rev2,
  output logic            raise_reserved,
  output logic            raise_disabled,
  output logic [4:0]      exc_code
);

  logic opcode_ok;

  always_comb
  begin
    opcode_ok      = rev2_present ? valid_rev2 : (valid_base & ~is_rev2);
    raise_reserved = 1'b0;
    raise_disabled = 1'b0;
    exc_code       = EXC_RESERVED;
    if (touches_ext)
    begin
      if (!base_present)
      begin
        raise_reserved = 1'b1;
      end
      else if (!ext_enable)
      begin
        raise_disabled = 1'b1;
        exc_code       = EXC_DISABLED;
      end
      else if ((is_rev2 && !rev2_present) || !opcode_ok)
      begin
        raise_reserved = 1'b1;
      end
    end
  end

endmodule // ext_exception_select

`default_nettype wire

// file: core/simd_ext_state_control.sv
// Purpose: Extension control register, four accumulator pairs, presence, enable and
//          exception selection for the SIMD signal-processing extension.
// Assumes: The pipeline offers one request per cycle and holds it while ready is low.
// Notes:   Datapath results (flags, carries, accumulator values) come from the pipeline.

`default_nettype none

module simd_ext_state_control
  import simd_ext_pkg::*;
#(
  parameter int unsigned ACC_W        = 64,
  parameter bit          BASE_PRESENT = 1'b1,
  parameter bit          REV2_PRESENT = 1'b1
)
(
  input  wire logic              ref_clk,
  input  wire logic              rstn,
  input  wire logic              req_valid,
  input  wire op_t               req_op,
  input  wire logic              req_is_ext,
  input  wire logic              req_is_rev2,
  input  wire logic              req_valid_base,
  input  wire logic              req_valid_rev2,
  input  wire logic [1:0]        req_acc,
  input  wire logic [31:0]       req_wdata,
  input  wire logic [7:0]        req_cmp_bits,
  input  wire logic [3:0]        req_cmp_count,
  input  wire logic              req_overflow,
  input  wire logic              req_carry,
  input  wire logic [5:0]        req_size,
  input  wire logic [ACC_W-1:0]  req_acc_hi,
  input  wire logic [ACC_W-1:0]  req_acc_lo,
  input  wire logic              stat_wr,
  input  wire logic [31:0]       stat_wdata,
  output logic                   req_ready,
  output logic                   done,
  output logic [31:0]            ctrl_value,
  output logic [31:0]            rd_data,
  output logic [ACC_W-1:0]       rd_acc_hi,
  output logic [ACC_W-1:0]       rd_acc_lo,
  output logic                   branch_taken,
  output logic                   carry_in,
  output logic [7:0]             select_bits,
  output logic                   exc_reserved,
  output logic                   exc_disabled,
  output logic [4:0]             exc_code,
  output logic [31:0]            config_word_three,
  output logic [31:0]            processor_status
);

  // ===========================================================================
  // State.
  typedef struct packed {
    logic [31:0]                       ctrl;
    logic [NUM_ACC-1:0][ACC_W-1:0]     acc_hi;
    logic [NUM_ACC-1:0][ACC_W-1:0]     acc_lo;
    logic                              enable;
    logic                              ready;
    logic                              done;
    logic [31:0]                       rd_data;
    logic [ACC_W-1:0]                  rd_hi;
    logic [ACC_W-1:0]                  rd_lo;
    logic                              taken;
    logic                              carry;
    logic [7:0]                        sel;
    logic                              exc_ri;
    logic                              exc_dis;
    logic [4:0]                        exc_code;
  } state_t;

  localparam state_t STATE_RESET = '{
    ctrl:     CTRL_RESET,
    acc_hi:   '0,
    acc_lo:   '0,
    enable:   EN_RESET,
    ready:    1'b1,
    done:     1'b0,
    rd_data:  32'h0000_0000,
    rd_hi:    '0,
    rd_lo:    '0,
    taken:    1'b0,
    carry:    1'b0,
    sel:      8'h00,
    exc_ri:   1'b0,
    exc_dis:  1'b0,
    exc_code: 5'h00
  };

  state_t state_q;
  state_t state_d;

  // ===========================================================================
  // Decode helpers.
  function automatic logic [7:0] cmp_mask(input logic [3:0] count);
    logic [7:0] m;
    m = 8'h00;
    case (count)
      4'h1:    m = 8'h01;
      4'h2:    m = 8'h03;
      4'h4:    m = 8'h0f;
      4'h8:    m = 8'hff;
      default: m = 8'h00;
    endcase
    return m;
  endfunction

  function automatic logic [7:0] ovf_set(input op_t op, input logic [1:0] acc);
    logic [7:0] s;
    s = 8'h00;
    case (op)
      OP_MAC_SAT:       s[acc] = 1'b1;
      OP_ADDSUB:        s[OU_ADDSUB_BIT - OUFLAG_LSB] = 1'b1;
      OP_ADD_USE_CARRY: s[OU_ADDSUB_BIT - OUFLAG_LSB] = 1'b1;
      OP_MUL_GPR:       s[OU_MUL_BIT - OUFLAG_LSB] = 1'b1;
      OP_PREC_SHIFT:    s[OU_PREC_BIT - OUFLAG_LSB] = 1'b1;
      OP_ACC_EXTRACT:   s[OU_ACCUMULATOR_EXTRACT_BIT - OUFLAG_LSB] = 1'b1;
      default:          s = 8'h00;
    endcase
    return s;
  endfunction

  // Whether an accepted operation may change the control register or an accumulator; variable inserts count too.
  function automatic logic writes_state(input op_t op);
    logic w;
    case (op)
      OP_READ_FULL, OP_SELECT, OP_BRANCH_POS32, OP_BRANCH_POS64, OP_ACC_READ, OP_OTHER:
        w = 1'b0;
      default:
        w = 1'b1;
    endcase
    return w;
  endfunction

  // ===========================================================================
  // Exception selection.
  logic       base_bit;
  logic       rev2_bit;
  logic       touches_ext;
  logic       raise_ri;
  logic       raise_dis;
  logic [4:0] raise_code;

  // A revision-2 bit without the base bit is treated as absent.
  assign base_bit    = BASE_PRESENT;
  assign rev2_bit    = REV2_PRESENT & BASE_PRESENT;
  assign touches_ext = req_is_ext
                     | (((req_op == OP_ACC_WRITE) || (req_op == OP_ACC_READ))
                        && (req_acc != 2'b00));

  ext_exception_select u_exc (
    .base_present   (base_bit),
    .rev2_present   (rev2_bit),
    .ext_enable     (state_q.enable),
    .touches_ext    (touches_ext),
    .is_rev2        (req_is_rev2),
    .valid_base     (req_valid_base),
    .valid_rev2     (req_valid_rev2),
    .raise_reserved (raise_ri),
    .raise_disabled (raise_dis),
    .exc_code       (raise_code)
  );

  // ===========================================================================
  // Next state.
  logic             accept;
  logic [6:0]       pos;
  logic [5:0]       scount;
  logic             fail;
  logic [6:0]       step;
  logic [ACC_W-1:0] sel_hi;
  logic [ACC_W-1:0] sel_lo;

  always_comb
  begin
    state_d          = state_q;
    accept           = req_valid & state_q.ready;
    pos              = state_q.ctrl[POS_LSB +: POS_W];
    scount           = state_q.ctrl[SCOUNT_LSB +: SCOUNT_W];
    fail             = ({1'b0, req_size} > pos);
    step             = 7'({1'b0, req_size} + 7'h01);
    sel_hi           = state_q.acc_hi[req_acc];
    sel_lo           = state_q.acc_lo[req_acc];
    state_d.done     = 1'b0;
    state_d.exc_ri   = 1'b0;
    state_d.exc_dis  = 1'b0;
    state_d.ready    = 1'b1;
    state_d.carry    = state_q.ctrl[CARRY_BIT];
    state_d.sel      = state_q.ctrl[CCOND_LSB +: 8];
    if (stat_wr)
    begin
      state_d.enable = stat_wdata[STAT_EN_BIT];
    end
    if (accept)
    begin
      state_d.done = 1'b1;
      // One bubble after any write lets the next reader see the committed value.
      state_d.ready = ~(writes_state(req_op) & ~raise_ri & ~raise_dis);
      if (raise_ri || raise_dis)
      begin
        state_d.exc_ri   = raise_ri;
        state_d.exc_dis  = raise_dis;
        state_d.exc_code = raise_code;
      end
      else
      begin
        if (req_overflow)
        begin
          state_d.ctrl[OUFLAG_LSB +: 8] = state_q.ctrl[OUFLAG_LSB +: 8]
                                        | ovf_set(req_op, req_acc);
        end
        case (req_op)
          OP_WRITE_FULL:
          begin
            state_d.ctrl = req_wdata & CTRL_WR_MASK;
          end
          OP_READ_FULL:
          begin
            state_d.rd_data = state_q.ctrl & CTRL_WR_MASK;
          end
          OP_COMPARE:
          begin
            // Bits above the element count are left as they were.
            state_d.ctrl[CCOND_LSB +: 8] = (state_q.ctrl[CCOND_LSB +: 8]
                                            & ~cmp_mask(req_cmp_count))
                                         | (req_cmp_bits & cmp_mask(req_cmp_count));
          end
          OP_ADD_GEN_CARRY:
          begin
            state_d.ctrl[CARRY_BIT] = req_carry;
          end
          OP_POS_EXTRACT:
          begin
            state_d.ctrl[EFI_BIT] = fail;
            state_d.rd_hi         = sel_hi;
            state_d.rd_lo         = sel_lo;
          end
          OP_POS_EXTRACT_DEC:
          begin
            state_d.ctrl[EFI_BIT] = fail;
            state_d.rd_hi         = sel_hi;
            state_d.rd_lo         = sel_lo;
            if (!fail)
            begin
              state_d.ctrl[POS_LSB +: POS_W] = 7'(pos - step);
            end
          end
          OP_VAR_INSERT:
          begin
            state_d.rd_data = {19'h00000, scount, pos};
          end
          OP_MOVE_LH:
          begin
            state_d.acc_hi[req_acc]        = sel_lo;
            state_d.acc_lo[req_acc]        = req_acc_lo;
            state_d.ctrl[POS_LSB +: POS_W] = 7'(pos + POS_ADV_WORD);
          end
          OP_MOVE_LH_DOUBLE:
          begin
            state_d.acc_hi[req_acc]        = sel_lo;
            state_d.acc_lo[req_acc]        = req_acc_lo;
            state_d.ctrl[POS_LSB +: POS_W] = 7'(pos + POS_ADV_DBL);
          end
          OP_BRANCH_POS32:
          begin
            state_d.taken = (pos >= POS_GE_WORD);
          end
          OP_BRANCH_POS64:
          begin
            state_d.taken = (pos >= POS_GE_DBL);
          end
          OP_MAC_SAT, OP_ACC_WRITE:
          begin
            state_d.acc_hi[req_acc] = req_acc_hi;
            state_d.acc_lo[req_acc] = req_acc_lo;
          end
          OP_ACC_READ, OP_ACC_EXTRACT:
          begin
            state_d.rd_hi = sel_hi;
            state_d.rd_lo = sel_lo;
          end
          default:
          begin
            state_d.done = 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      state_q <= STATE_RESET;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  // ===========================================================================
  // Outputs, each a register field.
  logic [31:0] cfg_q;
  logic [31:0] stat_q;

  always_ff @(posedge ref_clk)
  begin
    if (!rstn)
    begin
      cfg_q  <= 32'h0000_0000;
      stat_q <= 32'h0000_0000;
    end
    else
    begin
      cfg_q               <= 32'h0000_0000;
      cfg_q[CFG_BASE_BIT] <= base_bit;
      cfg_q[CFG_REV2_BIT] <= rev2_bit;
      stat_q              <= 32'h0000_0000;
      stat_q[STAT_EN_BIT] <= state_d.enable;
    end
  end

  assign req_ready         = state_q.ready;
  assign done              = state_q.done;
  assign ctrl_value        = state_q.ctrl;
  assign rd_data           = state_q.rd_data;
  assign rd_acc_hi         = state_q.rd_hi;
  assign rd_acc_lo         = state_q.rd_lo;
  assign branch_taken      = state_q.taken;
  assign carry_in          = state_q.carry;
  assign select_bits       = state_q.sel;
  assign exc_reserved      = state_q.exc_ri;
  assign exc_disabled      = state_q.exc_dis;
  assign exc_code          = state_q.exc_code;
  assign config_word_three = cfg_q;
  assign processor_status  = stat_q;

endmodule // simd_ext_state_control

`default_nettype wire

// file: tb/simd_ext_state_control_checker.sv
// Purpose: Port-level assertions for the extension state block.
// Assumes: One core clock, synchronous active-low reset.
// Notes:   Attached by the bind below the module.
`default_nettype none
module simd_ext_state_control_checker
  import simd_ext_pkg::*;
#(
  parameter bit BASE_PRESENT = 1'b1
)
(
  input wire logic        ref_clk,
  input wire logic        rstn,
  input wire logic        req_valid,
  input wire op_t         req_op,
  input wire logic        req_is_ext,
  input wire logic        req_valid_base,
  input wire logic        req_valid_rev2,
  input wire logic [1:0]  req_acc,
  input wire logic [31:0] req_wdata,
  input wire logic        req_overflow,
  input wire logic        req_carry,
  input wire logic [5:0]  req_size,
  input wire logic        req_ready,
  input wire logic        done,
  input wire logic [31:0] ctrl_value,
  input wire logic        exc_reserved,
  input wire logic        exc_disabled,
  input wire logic [4:0]  exc_code,
  input wire logic [31:0] processor_status
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       take;
  logic       en;
  logic       go;
  logic       wr_go;
  logic [7:0] ouf;
  logic [6:0] pos;
  logic [6:0] size7;
  assign take = req_valid && req_ready;
  assign en = processor_status[STAT_EN_BIT];
  assign go = take && en && req_valid_base;
  assign wr_go = go && req_op == OP_WRITE_FULL;
  assign ouf = ctrl_value[23:16];
  assign pos = ctrl_value[6:0];
  assign size7 = {1'b0, req_size};
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // A writing operation leaves one refused cycle behind it.
  sequence s_bubble;
    !req_ready ##1 req_ready;
  endsequence
  // ==========
  // Assertions.
  AST_RSVD_ZERO: assert property
    (ctrl_value[RSVD_BIT] == 1'b0)
    else $error("reserved control bit high");
  AST_WRITE_ALL: assert property
    (wr_go |=> done && ctrl_value == ($past(req_wdata) & CTRL_WR_MASK))
    else $error("full write not taken");
  AST_WRITE_BUBBLE: assert property
    (wr_go |=> s_bubble)
    else $error("no stall after write");
  AST_STICKY: assert property
    ($past(rstn) && !$past(wr_go) |-> (ouf & $past(ouf)) == $past(ouf))
    else $error("overflow flag cleared");
  AST_DISABLED: assert property
    (BASE_PRESENT && take && req_is_ext && !en && req_op < OP_ACC_WRITE
     |=> exc_disabled && exc_code == EXC_DISABLED)
    else $error("disabled exception missing");
  AST_RESERVED: assert property
    (take && req_is_ext && en && !req_valid_base && !req_valid_rev2
     |=> exc_reserved && exc_code == EXC_RESERVED)
    else $error("reserved exception missing");
  AST_CARRY: assert property
    (go && req_op == OP_ADD_GEN_CARRY |=> ctrl_value[CARRY_BIT] == $past(req_carry))
    else $error("carry bit wrong");
  AST_EXTRACT_FAIL: assert property
    (go && (req_op == OP_POS_EXTRACT || req_op == OP_POS_EXTRACT_DEC)
     |=> ctrl_value[EFI_BIT] == ($past(pos) < $past(size7)))
    else $error("extract fail bit wrong");
  AST_MAC_FLAG: assert property
    (go && req_op == OP_MAC_SAT && req_overflow |=> ctrl_value[OUFLAG_LSB + $past(req_acc)])
    else $error("accumulator overflow bit missing");
endmodule // simd_ext_state_control_checker

bind simd_ext_state_control simd_ext_state_control_checker
  #(.BASE_PRESENT(BASE_PRESENT)) chk_i
(
  .ref_clk, .rstn, .req_valid, .req_op, .req_is_ext, .req_valid_base, .req_valid_rev2,
  .req_acc, .req_wdata, .req_overflow, .req_carry, .req_size, .req_ready, .done,
  .ctrl_value, .exc_reserved, .exc_disabled, .exc_code, .processor_status
);
`default_nettype wire

// file: tb/pipeline_model.sv
// Purpose: Pipeline model offering extension requests to the state block.
// Assumes: Requests change at the falling edge and stay until taken or 16 rising edges pass.
// Notes:   One data word feeds every operand field of a request.
`default_nettype none
module pipeline_model
  import simd_ext_pkg::*;
(
  input  wire logic   ref_clk,
  input  wire logic   req_ready,
  output logic        req_valid,
  output op_t         req_op,
  output logic [3:0]  req_kind,
  output logic [1:0]  req_acc,
  output logic [31:0] req_data,
  output logic        stat_wr,
  output logic [31:0] stat_wdata,
  output logic        miss
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    req_valid = 1'b0;
    req_op = OP_OTHER;
    req_kind = 4'h0;
    req_acc = 2'h0;
    req_data = 32'h0;
    stat_wr = 1'b0;
    stat_wdata = 32'h0;
    miss = 1'b0;
  end
  // ==========
  // The request is held until a rising edge samples ready high, for at most 16 edges; otherwise miss is set.
  task automatic issue(input op_t op, input logic [3:0] kind, input logic [1:0] acc,
                       input logic [31:0] d);
    int n;
    @(negedge ref_clk);
    req_valid = 1'b1;
    req_op = op;
    req_kind = kind;
    req_acc = acc;
    req_data = d;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (!req_ready && n < 16);
    if (!req_ready)
      miss = 1'b1;
    @(negedge ref_clk);
    req_valid = 1'b0;
    req_data = ~d;
  endtask
  // Other status bits are driven high to show that they are ignored.
  task automatic set_enable(input logic e);
    @(negedge ref_clk);
    stat_wr = 1'b1;
    stat_wdata = {7'h7f, e, 24'hffffff};
    @(negedge ref_clk);
    stat_wr = 1'b0;
  endtask
endmodule // pipeline_model
`default_nettype wire

// file: tb/simd_ext_state_control_tb.sv
// Purpose: Self-checking bench for the extension state block.
// Assumes: Default parameters, both revisions present.
// Notes:   Kind bits are ext, rev2-only, valid base, valid rev2.
`default_nettype none
module simd_ext_state_control_tb
  import simd_ext_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [3:0] K_BASE = 4'hb;
  localparam logic [3:0] K_REV2 = 4'hd;
  localparam logic [3:0] K_BAD  = 4'h8;
  localparam logic [3:0] K_MOVE = 4'h3;
  logic        ref_clk, rstn, req_valid, stat_wr, miss, req_ready, done;
  logic        branch_taken, carry_in, exc_reserved, exc_disabled;
  logic [31:0] req_data, stat_wdata, ctrl_value, rd_data, config_word_three;
  logic [31:0] processor_status, exp;
  logic [63:0] rd_acc_hi, rd_acc_lo;
  logic [7:0]  select_bits, cc, m, b;
  logic [4:0]  exc_code;
  logic [3:0]  req_kind;
  logic [1:0]  req_acc;
  op_t         req_op;
  int          n_fail;
  int          checks;
  op_t ov_ops [8] = '{OP_MAC_SAT, OP_MAC_SAT, OP_MAC_SAT, OP_MAC_SAT, OP_ADDSUB,
                      OP_MUL_GPR, OP_PREC_SHIFT, OP_ACC_EXTRACT};

  simd_ext_state_control dut
  (
    .ref_clk, .rstn, .req_valid, .req_op, .req_acc, .stat_wr, .stat_wdata,
    .req_is_ext(req_kind[3]), .req_is_rev2(req_kind[2]),
    .req_valid_base(req_kind[1]), .req_valid_rev2(req_kind[0]),
    .req_wdata(req_data), .req_cmp_bits(req_data[15:8]), .req_cmp_count(req_data[19:16]),
    .req_overflow(req_data[7]), .req_carry(req_data[6]), .req_size(req_data[5:0]),
    .req_acc_hi({2{~req_data}}), .req_acc_lo({2{req_data}}),
    .req_ready, .done, .ctrl_value, .rd_data, .rd_acc_hi, .rd_acc_lo, .branch_taken,
    .carry_in, .select_bits, .exc_reserved, .exc_disabled, .exc_code,
    .config_word_three, .processor_status
  );
  pipeline_model pipe
  (
    .ref_clk, .req_ready, .req_valid, .req_op, .req_kind, .req_acc, .req_data,
    .stat_wr, .stat_wdata, .miss
  );

  initial ref_clk = 1'b0;
  always #20 ref_clk = ~ref_clk;

  // ==========
  // Shared tasks.
  task automatic chk(input string what, input logic [63:0] seen, input logic [63:0] want);
    checks++;
    if (seen !== want)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, want, seen);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic do_reset();
    @(negedge ref_clk);
    rstn = 1'b0;
    repeat (20) @(negedge ref_clk);
    rstn = 1'b1;
    @(negedge ref_clk);
  endtask

  // The run needs some 120 cycles; the watchdog allows 3000, about 25 times that.
  initial
  begin
    repeat (3000) @(posedge ref_clk);
    n_fail++;
    complete_run();
  end

  initial
  begin
    rstn = 1'b0;
    n_fail = 0;
    checks = 0;
    do_reset();
    chk("ctrl", ctrl_value, 64'h0);
    chk("presence", config_word_three[11:10], 64'h3);
    chk("ready", req_ready, 64'h1);
    $display("test reset ended");
    pipe.issue(OP_WRITE_FULL, K_BASE, 2'h0, 32'hffff7fff);
    chk("disabled", {exc_disabled, exc_code}, 64'h3a);
    chk("ctrl", ctrl_value, 64'h0);
    pipe.issue(OP_ACC_WRITE, K_MOVE, 2'h1, 32'h1);
    chk("acc1 move", exc_disabled, 64'h1);
    pipe.issue(OP_ACC_WRITE, K_MOVE, 2'h0, 32'h1);
    chk("acc0 move", {done, exc_disabled}, 64'h2);
    pipe.set_enable(1'b1);
    chk("status", processor_status, 64'h1000000);
    pipe.issue(OP_OTHER, K_BAD, 2'h0, 32'h0);
    chk("reserved", {exc_reserved, exc_code}, 64'h2a);
    pipe.issue(OP_OTHER, K_REV2, 2'h0, 32'h0);
    chk("valid rev2", {exc_reserved, exc_disabled}, 64'h0);
    $display("test access ended");
    pipe.issue(OP_WRITE_FULL, K_BASE, 2'h0, 32'hffff7fff);
    chk("ready bubble", req_ready, 64'h0);
    chk("ctrl", ctrl_value, 64'hffff7fff);
    pipe.issue(OP_READ_FULL, K_BASE, 2'h0, 32'h0);
    chk("full read", rd_data, 64'hffff7fff);
    pipe.issue(OP_WRITE_FULL, K_BASE, 2'h0, 32'h0);
    chk("ctrl", ctrl_value, 64'h0);
    exp = 32'h0;
    for (int i = 0; i < 8; i++)
    begin
      pipe.issue(ov_ops[i], K_BASE, (i < 4) ? i[1:0] : 2'h0, 32'h80);
      exp[16 + i] = 1'b1;
      chk("ouflag", ctrl_value, exp);
    end
    pipe.issue(OP_ADDSUB, K_BASE, 2'h0, 32'h0);
    chk("sticky", ctrl_value, exp);
    pipe.issue(OP_ADD_GEN_CARRY, K_BASE, 2'h0, 32'h40);
    chk("carry", ctrl_value[13], 64'h1);
    @(negedge ref_clk);
    chk("carry in", carry_in, 64'h1);
    $display("test flags ended");
    cc = 8'h0;
    for (int i = 3; i >= 0; i--)
    begin
      m = 8'hff >> (8 - (1 << i));
      b = i[0] ? 8'h00 : 8'hff;
      cc = (cc & ~m) | (b & m);
      pipe.issue(OP_COMPARE, K_BASE, 2'h0, {12'h0, 4'h1 << i, b, 8'h0});
      chk("ccond", ctrl_value[31:24], cc);
    end
    @(negedge ref_clk);
    chk("select", select_bits, cc);
    pipe.issue(OP_WRITE_FULL, K_BASE, 2'h0, 32'h2a8);
    pipe.issue(OP_VAR_INSERT, K_BASE, 2'h0, 32'h0);
    chk("insert args", rd_data, 64'h2a8);
    pipe.issue(OP_POS_EXTRACT_DEC, K_BASE, 2'h0, 32'ha);
    chk("extract dec", ctrl_value, 64'h29d);
    pipe.issue(OP_POS_EXTRACT_DEC, K_BASE, 2'h0, 32'h21);
    chk("extract fail", ctrl_value, 64'h429d);
    pipe.issue(OP_POS_EXTRACT, K_BASE, 2'h0, 32'h1d);
    chk("extract edge", ctrl_value, 64'h29d);
    pipe.issue(OP_BRANCH_POS32, K_BASE, 2'h0, 32'h0);
    chk("branch", branch_taken, 64'h0);
    pipe.issue(OP_ACC_WRITE, K_BASE, 2'h3, 32'h12345678);
    pipe.issue(OP_MOVE_LH, K_BASE, 2'h3, 32'h9abcdef0);
    chk("advance", ctrl_value[6:0], 64'h3d);
    pipe.issue(OP_ACC_READ, K_BASE, 2'h3, 32'h0);
    chk("acc hi", rd_acc_hi, {2{32'h12345678}});
    chk("acc lo", rd_acc_lo, {2{32'h9abcdef0}});
    pipe.issue(OP_ACC_READ, K_BASE, 2'h0, 32'h0);
    chk("acc0 lo", rd_acc_lo, 64'h0000008000000080);
    pipe.issue(OP_MOVE_LH_DOUBLE, K_BASE, 2'h3, 32'h0);
    chk("advance double", ctrl_value[6:0], 64'h7d);
    pipe.issue(OP_BRANCH_POS64, K_BASE, 2'h0, 32'h0);
    chk("branch", branch_taken, 64'h1);
    $display("test position ended");
    do_reset();
    chk("ctrl", ctrl_value, 64'h0);
    chk("status", processor_status, 64'h0);
    chk("held requests", miss, 64'h0);
    $display("test second reset ended");
    complete_run();
  end
endmodule // simd_ext_state_control_tb
`default_nettype wire
